// ===== dbfs_defs.vh
/*
 Constants of the dual buck fault supervisor: timing, register map,
 field layout and reset values.
 Assumes inclusion by bare name from the design files.
*/
`ifndef DBFS_DEFS_VH
`define DBFS_DEFS_VH

// Clock and delays
`define DBFS_CLK_MHZ 25
`define DBFS_START_US 2000
`define DBFS_QUAL_US 510
`define DBFS_UV_NS 32000
`define DBFS_DROP_NS 2000
`define DBFS_DEAD_NS 80
`define DBFS_START_CYC (`DBFS_START_US * `DBFS_CLK_MHZ)
`define DBFS_QUAL_CYC (`DBFS_QUAL_US * `DBFS_CLK_MHZ)
`define DBFS_UV_CYC ((`DBFS_UV_NS * `DBFS_CLK_MHZ + 999) / 1000)
`define DBFS_DROP_CYC ((`DBFS_DROP_NS * `DBFS_CLK_MHZ + 999) / 1000)
`define DBFS_DEAD_CYC ((`DBFS_DEAD_NS * `DBFS_CLK_MHZ + 999) / 1000)

// Register word indices (byte address = 4 * index)
`define DBFS_IDX_CTRL 6'h00
`define DBFS_IDX_STAT 6'h01

// Control register
`define DBFS_MODE_W 2
`define DBFS_MODE_PWM 2'h0
`define DBFS_MODE_SKIP 2'h1
`define DBFS_MODE_QUIET 2'h2
`define DBFS_CTRL_RST 2'h1

// Status register width, upper bits read zero
`define DBFS_STAT_W 16

// Bus responses
`define DBFS_RESP_OKAY 2'h0
`define DBFS_RESP_SLVERR 2'h2

// Synchronised input count
`define DBFS_NSYNC 27

`endif

// ===== dbfs_sync.v
/*
 Three-stage input synchroniser with agreement filter.
 Assumes asynchronous inputs and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module dbfs_sync #(
	parameter W = 1
) (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Data
	input wire [W-1:0] d_i,
	output reg [W-1:0] q_o
);
	reg [W-1:0] s1;
	reg [W-1:0] s2;
	reg [W-1:0] s3;

	// Output follows only where stages two and three agree
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s1 <= {W{1'b0}};
			s2 <= {W{1'b0}};
			s3 <= {W{1'b0}};
			q_o <= {W{1'b0}};
		end
		else
		begin
			s1 <= d_i;
			s2 <= s1;
			s3 <= s2;
			q_o <= (s2 & s3) | (q_o & (s2 ^ s3));
		end
	end
endmodule

// ===== dbfs_supervisor.v
/*
 Supervisor of a two-channel step-down controller: power-good, light-load
 override, discharge, LDO switchover, valley limit, dead time and faults,
 with an AXI4-Lite control and status port.
 Assumes analog comparators present digital flags on pins, synchronised here.
*/
// Summary of operation
// - 3.3 V LDO off, switch when ch2 good
// - Combined good is AND of channels
// - Good monitoring waits 2 ms after enable
// - Good rises after 510 us in 5% window
// - Good falls 2 us after leaving 10%
// - Overshoot in light load forces PWM
// - Discharge outputs while enable is low
// - Dead time between high and low gates
// - Hold high gate off above valley trip
// - Low limit pin shuts that channel down except a low gate held on by the 115% latch
// - 115% feedback latches high off, low on
// - Sense above 5.75 V blocks high gate
// - 32 us undervoltage latches all gates off
// - Undervoltage check waits 2 ms after enable
// - Supply lockout holds channels off, unlatched
// - Low 3.3 V supply shuts both channels except a low gate held on by the 115% latch
// - Overtemperature shuts gates and both LDOs, unlatched
// - 5 V LDO off, switch when ch1 good
`timescale 1ns/1ps
`include "dbfs_defs.vh"
module dbfs_supervisor #(
	parameter CNT_W = 16,
	parameter [CNT_W-1:0] START_CYCLES = `DBFS_START_CYC,
	parameter [CNT_W-1:0] QUAL_CYCLES = `DBFS_QUAL_CYC,
	parameter ADDR_W = 8
) (
	// Clock and reset
	input wire CLOCK_I,
	input wire SYS_RST_I,
	// Host control pins
	input wire SWITCHER_ENABLE_IN_I,
	input wire [1:0] CURRENT_LIMIT_SET_PIN_OK_I,
	// Channel comparators
	input wire [1:0] WINDOW5_I,
	input wire [1:0] WINDOW10_I,
	input wire [1:0] ABOVE10_I,
	input wire [1:0] FEEDBACK_SENSE_PIN_OVER115_I,
	input wire [1:0] FEEDBACK_SENSE_PIN_UNDER60_I,
	input wire [1:0] OUTPUT_SENSE_OVER575_I,
	input wire [1:0] VALLEY_CURRENT_LIMIT_I,
	input wire [1:0] ZERO_CURRENT_I,
	input wire [1:0] ON_TIME_REQ_I,
	// Supply and die monitors
	input wire OUTPUT_SENSE_CH1_ABOVE_4V7_I,
	input wire OUTPUT_SENSE_CH2_ABOVE_3V15_I,
	input wire SUPPLY_LOCKOUT_I,
	input wire LDO_THREE_VOLT_LOW_I,
	input wire OVER_TEMP_I,
	// Open-drain power-good pin
	input wire COMBINED_GOOD_OUT_I,
	output reg COMBINED_GOOD_OUT_O,
	output reg COMBINED_GOOD_OUT_OE_N_O,
	// Gate drives and discharge
	output wire [1:0] HIGH_SIDE_GATE_OUT_O,
	output wire [1:0] LOW_SIDE_GATE_OUT_O,
	output reg [1:0] DISCHARGE_ON_O,
	// Linear regulators
	output reg LDO_FIVE_VOLT_OUT_ON_O,
	output reg LDO_FIVE_VOLT_OUT_SWITCH_O,
	output reg LDO_THREE_VOLT_OUT_ON_O,
	output reg LDO_THREE_VOLT_OUT_SWITCH_O,
	// AXI4-Lite write
	input wire [ADDR_W-1:0] AXI_AWADDR_I,
	input wire AXI_AWVALID_I,
	output reg AXI_AWREADY_O,
	input wire [31:0] AXI_WDATA_I,
	input wire [3:0] AXI_WSTRB_I,
	input wire AXI_WVALID_I,
	output reg AXI_WREADY_O,
	output reg [1:0] AXI_BRESP_O,
	output reg AXI_BVALID_O,
	input wire AXI_BREADY_I,
	// AXI4-Lite read
	input wire [ADDR_W-1:0] AXI_ARADDR_I,
	input wire AXI_ARVALID_I,
	output reg AXI_ARREADY_O,
	output reg [31:0] AXI_RDATA_O,
	output reg [1:0] AXI_RRESP_O,
	output reg AXI_RVALID_O,
	input wire AXI_RREADY_I
);
	localparam integer UV_INT = `DBFS_UV_CYC;
	localparam integer DROP_INT = `DBFS_DROP_CYC;
	localparam integer DEAD_INT = `DBFS_DEAD_CYC;
	localparam [CNT_W-1:0] UV_CYC = UV_INT[CNT_W-1:0];
	localparam [CNT_W-1:0] DROP_CYC = DROP_INT[CNT_W-1:0];
	localparam [CNT_W-1:0] DEAD_CYC = DEAD_INT[CNT_W-1:0];
	localparam [CNT_W-1:0] ONE = 1;
	localparam [3:0] ST_OFF = 4'h1;
	localparam [3:0] ST_HIGH = 4'h2;
	localparam [3:0] ST_DEAD = 4'h4;
	localparam [3:0] ST_LOW = 4'h8;

	wire [`DBFS_NSYNC-1:0] raw;
	wire [`DBFS_NSYNC-1:0] syn;
	wire enable_s;
	wire [1:0] limit_ok;
	wire [1:0] win5;
	wire [1:0] win10;
	wire [1:0] above10;
	wire [1:0] over115;
	wire [1:0] under60;
	wire [1:0] over575;
	wire [1:0] valley;
	wire [1:0] zero_i;
	wire [1:0] on_req;
	wire ch1_4v7;
	wire ch2_3v15;
	wire lockout;
	wire ldo3_low;
	wire overtemp;
	wire pin_good;
	wire [1:0] pg_w;
	wire [1:0] ov_w;
	wire [1:0] uv_w;
	wire [1:0] force_w;
	wire [1:0] run_w;
	wire uv_any;
	wire run_common;
	wire latch_clr;
	reg [`DBFS_MODE_W-1:0] mode;
	reg [CNT_W-1:0] start_cnt;
	reg start_done;
	reg aw_held;
	reg w_held;
	reg [ADDR_W-1:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	wire [`DBFS_STAT_W-1:0] status;
	genvar i;

	// Pin inputs through three-stage synchroniser
	assign raw = {SWITCHER_ENABLE_IN_I, CURRENT_LIMIT_SET_PIN_OK_I, WINDOW5_I, WINDOW10_I,
		ABOVE10_I, FEEDBACK_SENSE_PIN_OVER115_I, FEEDBACK_SENSE_PIN_UNDER60_I,
		OUTPUT_SENSE_OVER575_I, VALLEY_CURRENT_LIMIT_I, ZERO_CURRENT_I, ON_TIME_REQ_I,
		OUTPUT_SENSE_CH1_ABOVE_4V7_I, OUTPUT_SENSE_CH2_ABOVE_3V15_I, SUPPLY_LOCKOUT_I,
		LDO_THREE_VOLT_LOW_I, OVER_TEMP_I, COMBINED_GOOD_OUT_I};
	assign {enable_s, limit_ok, win5, win10, above10, over115, under60, over575, valley,
		zero_i, on_req, ch1_4v7, ch2_3v15, lockout, ldo3_low, overtemp, pin_good} = syn;

	dbfs_sync #(
		.W(`DBFS_NSYNC)
	) u_sync (
		.clk_i(CLOCK_I),
		.rst_i(SYS_RST_I),
		.d_i(raw),
		.q_o(syn)
	);

	// Shared shutdown terms
	assign uv_any = |uv_w;
	assign run_common = enable_s & ~lockout & ~overtemp & ~ldo3_low & ~uv_any;
	assign latch_clr = ~enable_s | lockout;

	// Startup delay after enable
	always @(posedge CLOCK_I)
	begin
		if (SYS_RST_I || !enable_s)
		begin
			start_cnt <= {CNT_W{1'b0}};
			start_done <= 1'b0;
		end
		else if (!start_done)
		begin
			start_cnt <= start_cnt + ONE;
			start_done <= (start_cnt == START_CYCLES - ONE);
		end
	end

	generate
		for (i = 0; i < 2; i = i + 1)
		begin : g_ch
			reg pg;
			reg [CNT_W-1:0] qcnt;
			reg force_pwm;
			reg ov_lat;
			reg uv_lat;
			reg [CNT_W-1:0] uvcnt;
			reg [3:0] gst;
			reg [CNT_W-1:0] dcnt;
			wire run;
			wire hs_block;
			wire hs_want;
			wire ls_want;

			assign run = run_common & limit_ok[i];
			// Off-state valley limit and direct overvoltage block the high gate
			assign hs_block = (valley[i] & ~gst[1]) | over575[i];
			assign hs_want = run & ~ov_lat & on_req[i] & ~hs_block;
			assign ls_want = (ov_lat & ~uv_any & ~overtemp) |
				(run & ~on_req[i] & ((mode == `DBFS_MODE_PWM) | force_pwm | ~zero_i[i]));
			assign pg_w[i] = pg;
			assign ov_w[i] = ov_lat;
			assign uv_w[i] = uv_lat;
			assign force_w[i] = force_pwm;
			assign run_w[i] = run;
			assign HIGH_SIDE_GATE_OUT_O[i] = gst[1];
			assign LOW_SIDE_GATE_OUT_O[i] = gst[3];

			// Channel power-good qualification
			always @(posedge CLOCK_I)
			begin
				if (SYS_RST_I || !start_done || !run)
				begin
					pg <= 1'b0;
					qcnt <= {CNT_W{1'b0}};
				end
				else if (!pg)
				begin
					if (!win5[i])
						qcnt <= {CNT_W{1'b0}};
					else if (qcnt == QUAL_CYCLES - ONE)
					begin
						pg <= 1'b1;
						qcnt <= {CNT_W{1'b0}};
					end
					else
						qcnt <= qcnt + ONE;
				end
				else
				begin
					if (win10[i])
						qcnt <= {CNT_W{1'b0}};
					else if (qcnt == DROP_CYC - ONE)
					begin
						pg <= 1'b0;
						qcnt <= {CNT_W{1'b0}};
					end
					else
						qcnt <= qcnt + ONE;
				end
			end

			// Light-load overshoot override
			always @(posedge CLOCK_I)
			begin
				if (SYS_RST_I || mode == `DBFS_MODE_PWM)
					force_pwm <= 1'b0;
				else if (above10[i] && !pg)
					force_pwm <= 1'b1;
				else if (win5[i] && pg)
					force_pwm <= 1'b0;
			end

			// Latched over and undervoltage faults, set wins over clear
			always @(posedge CLOCK_I)
			begin
				if (SYS_RST_I)
				begin
					ov_lat <= 1'b0;
					uv_lat <= 1'b0;
					uvcnt <= {CNT_W{1'b0}};
				end
				else
				begin
					if (over115[i] && enable_s && !lockout)
						ov_lat <= 1'b1;
					else if (latch_clr)
						ov_lat <= 1'b0;
					if (under60[i] && start_done && run && !uv_lat)
					begin
						uvcnt <= uvcnt + ONE;
						if (uvcnt == UV_CYC - ONE)
							uv_lat <= 1'b1;
					end
					else
					begin
						uvcnt <= {CNT_W{1'b0}};
						if (latch_clr)
							uv_lat <= 1'b0;
					end
				end
			end

			// Gate sequencer with dead time
			always @(posedge CLOCK_I)
			begin
				if (SYS_RST_I)
				begin
					gst <= ST_OFF;
					dcnt <= {CNT_W{1'b0}};
				end
				else
				begin
					case (gst)
						ST_OFF:
						begin
							if (hs_want)
								gst <= ST_HIGH;
							else if (ls_want)
								gst <= ST_LOW;
						end
						ST_HIGH:
						begin
							if (!hs_want)
							begin
								gst <= ST_DEAD;
								dcnt <= {CNT_W{1'b0}};
							end
						end
						ST_LOW:
						begin
							if (!ls_want)
							begin
								gst <= ST_DEAD;
								dcnt <= {CNT_W{1'b0}};
							end
						end
						ST_DEAD:
						begin
							if (dcnt >= DEAD_CYC - ONE)
							begin
								if (hs_want)
									gst <= ST_HIGH;
								else if (ls_want)
									gst <= ST_LOW;
								else
									gst <= ST_OFF;
							end
							else
								dcnt <= dcnt + ONE;
						end
						default:
							gst <= ST_OFF;
					endcase
				end
			end
		end
	endgenerate

	// Power-good pin, discharge and regulators
	always @(posedge CLOCK_I)
	begin
		if (SYS_RST_I)
		begin
			COMBINED_GOOD_OUT_O <= 1'b0;
			COMBINED_GOOD_OUT_OE_N_O <= 1'b0;
			DISCHARGE_ON_O <= 2'h3;
			LDO_FIVE_VOLT_OUT_ON_O <= 1'b0;
			LDO_FIVE_VOLT_OUT_SWITCH_O <= 1'b0;
			LDO_THREE_VOLT_OUT_ON_O <= 1'b0;
			LDO_THREE_VOLT_OUT_SWITCH_O <= 1'b0;
		end
		else
		begin
			COMBINED_GOOD_OUT_O <= 1'b0;
			COMBINED_GOOD_OUT_OE_N_O <= pg_w[0] & pg_w[1];
			DISCHARGE_ON_O <= {2{~enable_s}};
			LDO_FIVE_VOLT_OUT_SWITCH_O <= ch1_4v7 & pg_w[0] & ~overtemp;
			LDO_FIVE_VOLT_OUT_ON_O <= ~overtemp & ~(ch1_4v7 & pg_w[0]);
			LDO_THREE_VOLT_OUT_SWITCH_O <= ch2_3v15 & pg_w[1] & ~overtemp;
			LDO_THREE_VOLT_OUT_ON_O <= ~overtemp & ~(ch2_3v15 & pg_w[1]);
		end
	end

	assign status = {start_done, overtemp, lockout, pin_good, LDO_FIVE_VOLT_OUT_SWITCH_O,
		LDO_THREE_VOLT_OUT_SWITCH_O, run_w, force_w, uv_w, ov_w, pg_w};

	// Bus write channel
	always @(posedge CLOCK_I)
	begin
		if (SYS_RST_I)
		begin
			AXI_AWREADY_O <= 1'b0;
			AXI_WREADY_O <= 1'b0;
			AXI_BVALID_O <= 1'b0;
			AXI_BRESP_O <= `DBFS_RESP_OKAY;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= {ADDR_W{1'b0}};
			w_data <= 32'h0;
			w_strb <= 4'h0;
			mode <= `DBFS_CTRL_RST;
		end
		else
		begin
			if (AXI_AWVALID_I && AXI_AWREADY_O)
			begin
				aw_held <= 1'b1;
				aw_addr <= AXI_AWADDR_I;
				AXI_AWREADY_O <= 1'b0;
			end
			else
				AXI_AWREADY_O <= !aw_held && !AXI_BVALID_O;
			if (AXI_WVALID_I && AXI_WREADY_O)
			begin
				w_held <= 1'b1;
				w_data <= AXI_WDATA_I;
				w_strb <= AXI_WSTRB_I;
				AXI_WREADY_O <= 1'b0;
			end
			else
				AXI_WREADY_O <= !w_held && !AXI_BVALID_O;
			if (aw_held && w_held && !AXI_BVALID_O)
			begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				AXI_BVALID_O <= 1'b1;
				if (aw_addr[ADDR_W-1:2] == `DBFS_IDX_CTRL)
				begin
					AXI_BRESP_O <= `DBFS_RESP_OKAY;
					if (w_strb[0])
						mode <= w_data[`DBFS_MODE_W-1:0];
				end
				else if (aw_addr[ADDR_W-1:2] == `DBFS_IDX_STAT)
					AXI_BRESP_O <= `DBFS_RESP_OKAY;
				else
					AXI_BRESP_O <= `DBFS_RESP_SLVERR;
			end
			else if (AXI_BVALID_O && AXI_BREADY_I)
				AXI_BVALID_O <= 1'b0;
		end
	end

	// Bus read channel
	always @(posedge CLOCK_I)
	begin
		if (SYS_RST_I)
		begin
			AXI_ARREADY_O <= 1'b0;
			AXI_RVALID_O <= 1'b0;
			AXI_RDATA_O <= 32'h0;
			AXI_RRESP_O <= `DBFS_RESP_OKAY;
		end
		else if (AXI_ARVALID_I && AXI_ARREADY_O)
		begin
			AXI_ARREADY_O <= 1'b0;
			AXI_RVALID_O <= 1'b1;
			if (AXI_ARADDR_I[ADDR_W-1:2] == `DBFS_IDX_CTRL)
			begin
				AXI_RDATA_O <= {{(32-`DBFS_MODE_W){1'b0}}, mode};
				AXI_RRESP_O <= `DBFS_RESP_OKAY;
			end
			else if (AXI_ARADDR_I[ADDR_W-1:2] == `DBFS_IDX_STAT)
			begin
				AXI_RDATA_O <= {{(32-`DBFS_STAT_W){1'b0}}, status};
				AXI_RRESP_O <= `DBFS_RESP_OKAY;
			end
			else
			begin
				AXI_RDATA_O <= 32'h0;
				AXI_RRESP_O <= `DBFS_RESP_SLVERR;
			end
		end
		else
		begin
			if (AXI_RVALID_O && AXI_RREADY_I)
				AXI_RVALID_O <= 1'b0;
			AXI_ARREADY_O <= !AXI_RVALID_O || AXI_RREADY_I;
		end
	end
endmodule

// ===== dbfs_monitor.sv
/*
 Pin checker of the supervisor: gates, discharge, regulators, faults.
 Assumes a bind to dbfs_supervisor by port name.
*/
`timescale 1ns/1ps
module dbfs_monitor (
	// Clock and reset
	input wire CLOCK_I,
	input wire SYS_RST_I,
	// Causes
	input wire SWITCHER_ENABLE_IN_I,
	input wire [1:0] CURRENT_LIMIT_SET_PIN_OK_I,
	input wire [1:0] OUTPUT_SENSE_OVER575_I,
	input wire [1:0] VALLEY_CURRENT_LIMIT_I,
	input wire SUPPLY_LOCKOUT_I,
	input wire OVER_TEMP_I,
	// Effects
	input wire [1:0] HIGH_SIDE_GATE_OUT_O,
	input wire [1:0] LOW_SIDE_GATE_OUT_O,
	input wire [1:0] DISCHARGE_ON_O,
	input wire LDO_FIVE_VOLT_OUT_ON_O,
	input wire LDO_THREE_VOLT_OUT_ON_O
);
	logic [3:0] up;
	wire ok = up == 4'h8;
	wire [1:0] hs = HIGH_SIDE_GATE_OUT_O;
	wire [1:0] ls = LOW_SIDE_GATE_OUT_O;
	wire [1:0] gon = hs | ls;
	// Cycles since reset, saturating
	always_ff @(posedge CLOCK_I)
		up <= SYS_RST_I ? 4'h0 : up + {3'h0, !ok};
	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (SYS_RST_I);
	property p_lap; (hs & ls) == 2'h0; endproperty
	a_lap: assert property (p_lap) else $error("gates overlap");
	property p_dead; $fell(hs[0]) || $fell(ls[0]) |-> (gon[0] == 1'b0) [*2]; endproperty
	a_dead: assert property (p_dead) else $error("no dead time");
	property p_dis; (ok && !SWITCHER_ENABLE_IN_I) [*8] |-> DISCHARGE_ON_O == 2'h3; endproperty
	a_dis: assert property (p_dis) else $error("discharge off");
	property p_val; (ok && VALLEY_CURRENT_LIMIT_I[0] && !hs[0]) [*8] |=> !hs[0]; endproperty
	a_val: assert property (p_val) else $error("valley ignored");
	property p_lim; (ok && !CURRENT_LIMIT_SET_PIN_OK_I[0]) [*8] |-> !gon[0]; endproperty
	a_lim: assert property (p_lim) else $error("channel not shut");
	property p_ov; (ok && OUTPUT_SENSE_OVER575_I[0]) [*8] |-> !hs[0]; endproperty
	a_ov: assert property (p_ov) else $error("high gate on");
	property p_lock; (ok && SUPPLY_LOCKOUT_I) [*8] |-> gon == 2'h0; endproperty
	a_lock: assert property (p_lock) else $error("lockout ignored");
	property p_hot;
		(ok && OVER_TEMP_I) [*8] |->
			gon == 2'h0 && !LDO_FIVE_VOLT_OUT_ON_O && !LDO_THREE_VOLT_OUT_ON_O;
	endproperty
	a_hot: assert property (p_hot) else $error("hot not off");
	c_on: cover property ($rose(hs[0]));
	c_off: cover property ($fell(ls[0]));
	c_run: cover property (DISCHARGE_ON_O == 2'h0);
endmodule

// ===== dbfs_stage_model.sv
/*
 Power stage model: sense flags from a level code, on-time pulses.
 Codes: 0 in 5%, 1 in 10%, 2 above 10%, 3 over 115%, 4 under 60%.
*/
`timescale 1ns/1ps
module dbfs_stage_model (
	// Clock
	input wire clk_i,
	// Level codes, three bits a channel
	input wire [5:0] lvl_i,
	// Sense flags and on-time requests
	output logic [1:0] win5_o,
	output logic [1:0] win10_o,
	output logic [1:0] ab10_o,
	output logic [1:0] ov115_o,
	output logic [1:0] un60_o,
	output logic [1:0] ton_o
);
	logic [2:0] cnt = 3'h0;
	always @(posedge clk_i)
		cnt <= cnt + 3'h1;
	assign ton_o = {2{cnt[2]}};
	always_comb
	begin
		for (int c = 0; c < 2; c++)
		begin
			win5_o[c] = lvl_i[3*c+:3] == 3'h0;
			win10_o[c] = lvl_i[3*c+:3] < 3'h2;
			ab10_o[c] = lvl_i[3*c+:3] == 3'h2 || lvl_i[3*c+:3] == 3'h3;
			ov115_o[c] = lvl_i[3*c+:3] == 3'h3;
			un60_o[c] = lvl_i[3*c+:3] == 3'h4;
		end
	end
endmodule

// ===== dbfs_tb.sv
/*
 Testbench of the supervisor: bus tasks, start-up, window and fault runs.
 Assumes the supervisor, its checker and the stage model.
*/
`timescale 1ns/1ps
module testbench;
	logic CLOCK_I = 1'b0, SYS_RST_I = 1'b1, SWITCHER_ENABLE_IN_I = 1'b0;
	logic [5:0] flt = 6'h0;
	logic [5:0] lvl = 6'h0;
	logic [1:0] CURRENT_LIMIT_SET_PIN_OK_I, VALLEY_CURRENT_LIMIT_I, OUTPUT_SENSE_OVER575_I;
	logic [1:0] WINDOW5_I, WINDOW10_I, ABOVE10_I, FEEDBACK_SENSE_PIN_OVER115_I;
	logic [1:0] FEEDBACK_SENSE_PIN_UNDER60_I, ZERO_CURRENT_I, ON_TIME_REQ_I;
	logic OUTPUT_SENSE_CH1_ABOVE_4V7_I, OUTPUT_SENSE_CH2_ABOVE_3V15_I, SUPPLY_LOCKOUT_I;
	logic LDO_THREE_VOLT_LOW_I, OVER_TEMP_I, COMBINED_GOOD_OUT_I, COMBINED_GOOD_OUT_O;
	logic COMBINED_GOOD_OUT_OE_N_O, LDO_FIVE_VOLT_OUT_ON_O, LDO_FIVE_VOLT_OUT_SWITCH_O;
	logic LDO_THREE_VOLT_OUT_ON_O, LDO_THREE_VOLT_OUT_SWITCH_O;
	logic [1:0] HIGH_SIDE_GATE_OUT_O, LOW_SIDE_GATE_OUT_O, DISCHARGE_ON_O;
	logic [7:0] AXI_AWADDR_I = 8'h0, AXI_ARADDR_I = 8'h0;
	logic [31:0] AXI_WDATA_I = 32'h0, AXI_RDATA_O, rd;
	logic [3:0] AXI_WSTRB_I = 4'hf;
	logic AXI_AWVALID_I = 1'b0, AXI_WVALID_I = 1'b0, AXI_BREADY_I = 1'b0;
	logic AXI_ARVALID_I = 1'b0, AXI_RREADY_I = 1'b0;
	logic AXI_AWREADY_O, AXI_WREADY_O, AXI_BVALID_O, AXI_ARREADY_O, AXI_RVALID_O;
	logic [1:0] AXI_BRESP_O, AXI_RRESP_O, rsp;
	int error_cnt = 0;
	int comparisons = 0;
	// Fault inputs from one vector
	assign CURRENT_LIMIT_SET_PIN_OK_I = {1'b1, ~flt[0]};
	assign SUPPLY_LOCKOUT_I = flt[1];
	assign LDO_THREE_VOLT_LOW_I = flt[2];
	assign OVER_TEMP_I = flt[3];
	assign VALLEY_CURRENT_LIMIT_I = {2{flt[4]}};
	assign OUTPUT_SENSE_OVER575_I = {2{flt[5]}};
	assign ZERO_CURRENT_I = 2'h0;
	assign OUTPUT_SENSE_CH1_ABOVE_4V7_I = WINDOW10_I[0];
	assign OUTPUT_SENSE_CH2_ABOVE_3V15_I = WINDOW10_I[1];
	// Pulled-up good pin
	assign COMBINED_GOOD_OUT_I = COMBINED_GOOD_OUT_OE_N_O;
	initial forever #20 CLOCK_I = ~CLOCK_I;
	dbfs_supervisor #(.START_CYCLES(16'd20), .QUAL_CYCLES(16'd10)) uut (.*);
	dbfs_stage_model stage (.clk_i(CLOCK_I), .lvl_i(lvl), .win5_o(WINDOW5_I),
		.win10_o(WINDOW10_I), .ab10_o(ABOVE10_I), .ov115_o(FEEDBACK_SENSE_PIN_OVER115_I),
		.un60_o(FEEDBACK_SENSE_PIN_UNDER60_I), .ton_o(ON_TIME_REQ_I));
	task automatic wt(input int n);
		repeat (n) @(posedge CLOCK_I);
	endtask
	task automatic chk(input logic [31:0] v, input logic [31:0] e);
		comparisons++;
		if (v !== e)
		begin
			error_cnt++;
			$display("ERROR %0t: got %h expected %h", $time, v, e);
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		@(posedge CLOCK_I);
		AXI_AWADDR_I <= a;
		AXI_WDATA_I <= d;
		AXI_AWVALID_I <= 1'b1;
		AXI_WVALID_I <= 1'b1;
		AXI_BREADY_I <= 1'b1;
		do
		begin
			@(posedge CLOCK_I);
			if (AXI_AWREADY_O)
				AXI_AWVALID_I <= 1'b0;
			if (AXI_WREADY_O)
				AXI_WVALID_I <= 1'b0;
		end
		while (AXI_BVALID_O !== 1'b1);
		rsp = AXI_BRESP_O;
		AXI_BREADY_I <= 1'b0;
	endtask
	task automatic axr(input logic [7:0] a);
		@(posedge CLOCK_I);
		AXI_ARADDR_I <= a;
		AXI_ARVALID_I <= 1'b1;
		AXI_RREADY_I <= 1'b1;
		do
		begin
			@(posedge CLOCK_I);
			if (AXI_ARREADY_O)
				AXI_ARVALID_I <= 1'b0;
		end
		while (AXI_RVALID_O !== 1'b1);
		rd = AXI_RDATA_O;
		rsp = AXI_RRESP_O;
		AXI_RREADY_I <= 1'b0;
	endtask
	task automatic stop_test;
		$display("Comparisons %0d, errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		wt(20000);
		error_cnt++;
		stop_test;
	end
	initial
	begin
		wt(12);
		SYS_RST_I <= 1'b0;
		wt(2);
		// Registers and unmapped place
		axr(8'h00);
		chk(rd, 32'h1);
		axw(8'h00, 32'h2);
		axr(8'h00);
		chk(rd, 32'h2);
		axw(8'h04, 32'hffff);
		axr(8'h04);
		chk(rd, 32'h0);
		axw(8'h10, 32'h1);
		chk(rsp, 2'h2);
		axr(8'h10);
		chk(rd, 32'h0);
		chk(rsp, 2'h2);
		chk(DISCHARGE_ON_O, 2'h3);
		// Start-up
		SWITCHER_ENABLE_IN_I <= 1'b1;
		wt(28);
		chk(COMBINED_GOOD_OUT_OE_N_O, 1'b0);
		wt(22);
		chk(COMBINED_GOOD_OUT_OE_N_O, 1'b1);
		chk(COMBINED_GOOD_OUT_O, 1'b0);
		chk(DISCHARGE_ON_O, 2'h0);
		chk({LDO_THREE_VOLT_OUT_SWITCH_O, LDO_THREE_VOLT_OUT_ON_O}, 2'h2);
		chk({LDO_FIVE_VOLT_OUT_SWITCH_O, LDO_FIVE_VOLT_OUT_ON_O}, 2'h2);
		// Channel 2 above the window in quiet mode
		lvl <= 6'o20;
		wt(40);
		chk(COMBINED_GOOD_OUT_OE_N_O, 1'b1);
		wt(30);
		chk(COMBINED_GOOD_OUT_OE_N_O, 1'b0);
		axr(8'h04);
		chk(rd[7:0], 8'h81);
		lvl <= 6'o00;
		wt(40);
		axr(8'h04);
		chk(rd[7:0], 8'h03);
		// Overvoltage latch on channel 1
		lvl <= 6'o03;
		wt(10);
		chk({HIGH_SIDE_GATE_OUT_O[0], LOW_SIDE_GATE_OUT_O[0]}, 2'h1);
		lvl <= 6'o00;
		wt(10);
		chk(LOW_SIDE_GATE_OUT_O[0], 1'b1);
		SWITCHER_ENABLE_IN_I <= 1'b0;
		wt(10);
		axr(8'h04);
		chk(rd[5:2], 4'h0);
		// Undervoltage from enable
		lvl <= 6'o40;
		SWITCHER_ENABLE_IN_I <= 1'b1;
		wt(815);
		axr(8'h04);
		chk(rd[5:4], 2'h0);
		wt(25);
		axr(8'h04);
		chk(rd[5:4], 2'h2);
		chk(HIGH_SIDE_GATE_OUT_O | LOW_SIDE_GATE_OUT_O, 2'h0);
		SWITCHER_ENABLE_IN_I <= 1'b0;
		lvl <= 6'o00;
		wt(10);
		SWITCHER_ENABLE_IN_I <= 1'b1;
		wt(60);
		// Unlatched shutdowns and gate blocks
		for (int k = 0; k < 6; k++)
		begin
			flt <= 6'h1 << k;
			wt(16);
			chk(HIGH_SIDE_GATE_OUT_O[0], 1'b0);
			if (k < 4)
				chk(HIGH_SIDE_GATE_OUT_O[0] | LOW_SIDE_GATE_OUT_O[0], 1'b0);
			flt <= 6'h0;
			wt(10);
		end
		// PWM mode: overshoot drops good but forces nothing
		axw(8'h00, 32'h0);
		lvl <= 6'o20;
		wt(70);
		axr(8'h04);
		chk(rd[7:6], 2'h0);
		chk(rd[1], 1'b0);
		stop_test;
	end
endmodule
bind dbfs_supervisor dbfs_monitor mon (.*);
